// ==== asct_ctrl_top.sv ====
// What this block does
// - Stop request 32 clocks before data ready ends conversions after current.
// - Commands are accepted regardless of data ready, but not during reset hold or recovery.
// - Data ready rises within two clocks of start or first frame clock.
// - Data ready high pulse lasts at least 24 converter clocks.
// - Incomplete byte with no serial clock fall for 32768 clocks resets serial logic.
// - GPIO outputs update on last falling clock of register write.
// - Serial input bit is captured on each serial clock fall.
// - Next serial output bit is shifted out on each serial clock rise.
// - Serial output driven while chip select low, released when high.
// - Bytes and commands follow back to back with no idle time.
// - All cycle limits count periods of the converter clock.
`timescale 1ns/10ps
module asct_ctrl_top #(
   parameter int CLK_DIV = asct_pkg::CLK_DIV,
   parameter int CONV_LEN = asct_pkg::CONV_TCLK,
   parameter int RST_WAIT = asct_pkg::RST_WAIT_TCLK,
   parameter int BYTE_TIMEOUT = asct_pkg::BYTE_TIMEOUT_TCLK
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic din_i,
   input wire logic start_i,
   input wire logic reset_n_i,
   input wire logic continuous_i,
   input wire logic [asct_pkg::DATA_W-1:0] conv_result_i,
   output logic conversion_done_n_o,
   output logic serial_out_with_done_o,
   output logic serial_out_oe_n_o,
   output logic [asct_pkg::GPIO_W-1:0] gpio_o,
   output logic converting_o
);
   localparam logic [15:0] DIV_LAST = 16'(CLK_DIV - 1);
   localparam logic [15:0] CONV_LAST = 16'(CONV_LEN - 1);
   localparam logic [15:0] RAISE_AT = 16'(CONV_LEN - 1 - asct_pkg::DONE_HIGH_TCLK);
   localparam logic [15:0] STOP_MIN = 16'(asct_pkg::STOP_SETUP_TCLK);
   localparam logic [15:0] RECOV_LOAD = 16'(RST_WAIT);
   localparam logic [15:0] TMO_LAST = 16'(BYTE_TIMEOUT - 1);
   localparam logic [2:0] RLOW_MAX = 3'(asct_pkg::RST_LOW_TCLK);
   localparam logic [4:0] HI_MIN = 5'(asct_pkg::DONE_HIGH_TCLK);
   localparam logic [4:0] HI_SAT = 5'h1F;
   localparam int MSB = asct_pkg::DATA_W - 1;

   asct_pin_if pin ();
   asct_pkg::asct_state_t st_r;
   asct_pkg::asct_state_t st_nxt;

   logic ser_ok;
   logic fall_ok;
   logic rise_ok;
   logic at7;
   logic at8;
   logic [7:0] byte_w;
   logic cmd_reset;
   logic cmd_start;
   logic cmd_stop;
   logic start_req;
   logic stop_req;
   logic conv_end;
   logic rst_now;

   // Opcode match on the seven bits known at the seventh falling edge
   function automatic logic op7(input logic [7:0] sr, input logic [7:0] cmd);
      return sr[6:0] == cmd[7:1];
   endfunction

   asct_pin_sync u_sync (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .cs_n_i(cs_n_i),
      .sclk_i(sclk_i),
      .din_i(din_i),
      .start_i(start_i),
      .reset_n_i(reset_n_i),
      .pin(pin.smp)
   );

   // Serial events are masked during reset hold and recovery
   assign ser_ok = !pin.cs_n && (st_r.recov == 16'h0000) && !st_r.rst_hold;
   assign fall_ok = ser_ok && pin.sclk_fall;
   assign rise_ok = ser_ok && pin.sclk_rise;
   assign byte_w = {st_r.sr[6:0], pin.din};
   assign at7 = fall_ok && (st_r.bitcnt == 3'h6) && (st_r.sp == asct_pkg::SP_CMD);
   assign at8 = fall_ok && (st_r.bitcnt == 3'h7);

   // Opcodes act outside reset hold and recovery, data ready state is not consulted
   assign cmd_reset = at7 && op7(byte_w, asct_pkg::CMD_RESET);
   assign cmd_start = at7 && op7(byte_w, asct_pkg::CMD_START);
   assign cmd_stop = at7 && op7(byte_w, asct_pkg::CMD_STOP);
   assign start_req = pin.start_rise || cmd_start;
   assign stop_req = pin.start_fall || cmd_stop;
   assign rst_now = !pin.rst_n && (st_r.rlow == RLOW_MAX);
   assign conv_end = (st_r.cv == asct_pkg::CV_RUN) && st_r.tick && (st_r.conv_cnt >= CONV_LAST)
                     && st_r.done_n && (st_r.hi_cnt >= HI_MIN);

   // Next state of the whole block
   always_comb begin
      asct_pkg::asct_state_t keep;
      keep = st_r;
      st_nxt = st_r;
      st_nxt.tick = 1'b0;

      // Converter clock enable from the system clock
      if (st_r.div == DIV_LAST) begin
         st_nxt.div = 16'h0000;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.div = st_r.div + 16'h0001;
      end

      // Reset pin low time in converter clocks
      if (pin.rst_n) begin
         st_nxt.rlow = 3'h0;
      end else if (st_r.tick && (st_r.rlow != RLOW_MAX)) begin
         st_nxt.rlow = st_r.rlow + 3'h1;
      end

      // Recovery countdown after a reset
      if (st_r.tick && (st_r.recov != 16'h0000)) begin
         st_nxt.recov = st_r.recov - 16'h0001;
      end

      // Byte timeout while a byte is partly received
      if (st_r.bitcnt == 3'h0) begin
         st_nxt.tmo = 16'h0000;
      end else if (st_r.tick) begin
         if (st_r.tmo == TMO_LAST) begin
            st_nxt.tmo = 16'h0000;
            st_nxt.bitcnt = 3'h0;
            st_nxt.sp = asct_pkg::SP_CMD;
         end else begin
            st_nxt.tmo = st_r.tmo + 16'h0001;
         end
      end

      // Data ready high time, saturating
      if (st_r.tick && st_r.done_n && (st_r.hi_cnt != HI_SAT)) begin
         st_nxt.hi_cnt = st_r.hi_cnt + 5'h01;
      end

      // Conversion timing
      if ((st_r.cv == asct_pkg::CV_RUN) && st_r.tick) begin
         if (st_r.conv_cnt < CONV_LAST) begin
            st_nxt.conv_cnt = st_r.conv_cnt + 16'h0001;
         end
         if ((st_r.conv_cnt == RAISE_AT) && !st_r.done_n) begin
            st_nxt.done_n = 1'b1;
            st_nxt.hi_cnt = 5'h00;
         end
      end
      if (conv_end) begin
         st_nxt.done_n = 1'b0;
         st_nxt.conv_cnt = 16'h0000;
         st_nxt.out_sr = conv_result_i;
         st_nxt.out_active = 1'b1;
         st_nxt.stop_pend = st_r.stop_late;
         st_nxt.stop_late = 1'b0;
         if (!continuous_i || st_r.stop_pend) begin
            st_nxt.cv = asct_pkg::CV_IDLE;
         end
      end

      // Stop takes the current conversion as last only with enough setup
      if (stop_req && (st_r.cv == asct_pkg::CV_RUN) && !conv_end) begin
         if ((CONV_LAST - st_r.conv_cnt) >= STOP_MIN) begin
            st_nxt.stop_pend = 1'b1;
         end else begin
            st_nxt.stop_late = 1'b1;
         end
      end

      // Start or resync: raise data ready and restart the conversion
      if (start_req) begin
         st_nxt.cv = asct_pkg::CV_RUN;
         st_nxt.conv_cnt = 16'h0000;
         st_nxt.stop_pend = 1'b0;
         st_nxt.stop_late = 1'b0;
         st_nxt.done_n = 1'b1;
         st_nxt.hi_cnt = 5'h00;
      end

      // Serial clock rise: first one in frame raises data ready, then shift out
      if (rise_ok) begin
         if (!st_r.frame_first) begin
            st_nxt.frame_first = 1'b1;
            if (!st_r.done_n) begin
               st_nxt.done_n = 1'b1;
               st_nxt.hi_cnt = 5'h00;
            end
         end
         if (st_r.out_active) begin
            st_nxt.dout = st_r.out_sr[MSB];
            st_nxt.out_sr = {st_r.out_sr[MSB-1:0], 1'b0};
         end
      end else if (!st_r.out_active || !st_r.frame_first) begin
         st_nxt.dout = st_nxt.done_n;
      end

      // Serial clock fall: capture, count bits, wrap straight into next byte
      if (fall_ok) begin
         st_nxt.sr = byte_w;
         st_nxt.bitcnt = st_r.bitcnt + 3'h1;
         st_nxt.tmo = 16'h0000;
      end
      if (at8) begin
         if (st_r.sp == asct_pkg::SP_WDATA) begin
            st_nxt.gpio = byte_w[asct_pkg::GPIO_W-1:0];
            st_nxt.sp = asct_pkg::SP_CMD;
         end else if (byte_w == asct_pkg::CMD_REGISTER_WRITE_COMMAND) begin
            st_nxt.sp = asct_pkg::SP_WDATA;
         end else if (byte_w == asct_pkg::CMD_RDATA) begin
            st_nxt.out_sr = st_r.out_active ? st_r.out_sr : conv_result_i;
            st_nxt.out_active = 1'b1;
         end
      end

      // Frame end clears the byte framing and consumed readout
      if (pin.cs_n) begin
         st_nxt.bitcnt = 3'h0;
         st_nxt.sp = asct_pkg::SP_CMD;
         st_nxt.frame_first = 1'b0;
         if (st_r.frame_first) begin
            st_nxt.out_active = 1'b0;
         end
      end

      // Reset pin hold, release, or reset command
      if (rst_now || cmd_reset) begin
         keep = st_nxt;
         st_nxt = asct_pkg::ST_RST;
         st_nxt.div = keep.div;
         st_nxt.tick = keep.tick;
         st_nxt.rlow = keep.rlow;
         st_nxt.rst_hold = rst_now;
         st_nxt.recov = rst_now ? 16'h0000 : RECOV_LOAD;
      end else if (st_r.rst_hold && pin.rst_n) begin
         st_nxt.rst_hold = 1'b0;
         st_nxt.recov = RECOV_LOAD;
      end

      st_nxt.converting = (st_nxt.cv == asct_pkg::CV_RUN);
      st_nxt.oe_n = pin.cs_n;
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= asct_pkg::ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from state flops
   assign conversion_done_n_o = st_r.done_n;
   assign serial_out_with_done_o = st_r.dout;
   assign serial_out_oe_n_o = st_r.oe_n;
   assign gpio_o = st_r.gpio;
   assign converting_o = st_r.converting;

   // Checks on the block's own behaviour
   sequence s_write_last;
      at8 && (st_r.sp == asct_pkg::SP_WDATA);
   endsequence

   sequence s_stop_early;
      st_r.stop_pend && continuous_i ##0 conv_end;
   endsequence

   a_oe_follows_cs: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      ##1 serial_out_oe_n_o == $past(pin.cs_n))
      else $error("output enable does not follow chip select");

   a_din_capture: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      fall_ok && !rst_now && !cmd_reset |=> st_r.sr[0] == $past(pin.din))
      else $error("serial input bit not captured on falling edge");

   a_dout_shift: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      rise_ok && st_r.out_active && !rst_now |=> serial_out_with_done_o == $past(st_r.out_sr[MSB]))
      else $error("serial output bit not shifted on rising edge");

   a_done_rise_start: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      pin.start_rise |-> ##[1:2] conversion_done_n_o)
      else $error("data ready not raised after start");

   a_done_high_min: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      $fell(conversion_done_n_o) |-> $past(st_r.hi_cnt) >= HI_MIN)
      else $error("data ready high pulse too short");

   a_gpio_update: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      s_write_last and !rst_now and !cmd_reset |=> gpio_o == $past(byte_w[asct_pkg::GPIO_W-1:0]))
      else $error("gpio not updated at end of register write");

   a_byte_timeout: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      st_r.tick && (st_r.tmo == TMO_LAST) && (st_r.bitcnt != 3'h0) && !fall_ok
      |=> st_r.bitcnt == 3'h0)
      else $error("serial logic not reset after byte timeout");

   a_stop_halts: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      s_stop_early and !start_req and !rst_now and !cmd_reset |=> !converting_o)
      else $error("conversions continue after early stop");

   a_byte_wrap: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      at8 && !pin.cs_n && !rst_now && !cmd_reset |=> st_r.bitcnt == 3'h0)
      else $error("bit counter does not wrap into next byte");

   a_reset_hold: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      rst_now |=> st_r.rst_hold && (gpio_o == asct_pkg::GPIO_RST) && !converting_o)
      else $error("reset pin not honoured");

   a_recovery_load: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      st_r.rst_hold && pin.rst_n |=> st_r.recov == RECOV_LOAD)
      else $error("recovery count not loaded after reset release");

endmodule // asct_ctrl_top

// ==== asct_ctrl_top_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(g, e) chk(16'(g), 16'(e))
module asct_ctrl_top_tb_top;
   localparam int DIV = 2;
   localparam int RWAIT = 8;
   localparam int CONV_LEN = 64;
   localparam int BYTE_TMO = 64;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic cont = 1'b0;
   logic [asct_pkg::DATA_W-1:0] result = 16'h0000;
   logic cs_n;
   logic sclk;
   logic din;
   logic start;
   logic rst_n;
   logic done_n;
   logic dout;
   logic oe_n;
   logic conv;
   logic sdo_line;
   logic [asct_pkg::GPIO_W-1:0] gpio;
   logic done_q = 1'b1;
   logic [7:0] r1;
   logic [7:0] r2;
   int bad_count = 0;
   int checked = 0;
   int falls = 0;
   int hi_len = 0;
   int hi_min = 100000;
   int k;

   // 40 MHz system clock
   always #12.5 sys_clk = ~sys_clk;

   asct_ctrl_top #(
      .CLK_DIV(DIV),
      .CONV_LEN(CONV_LEN),
      .RST_WAIT(RWAIT),
      .BYTE_TIMEOUT(BYTE_TMO)
   ) dut (
      .sys_clk_i(sys_clk),
      .nrst_i(nrst),
      .cs_n_i(cs_n),
      .sclk_i(sclk),
      .din_i(din),
      .start_i(start),
      .reset_n_i(rst_n),
      .continuous_i(cont),
      .conv_result_i(result),
      .conversion_done_n_o(done_n),
      .serial_out_with_done_o(dout),
      .serial_out_oe_n_o(oe_n),
      .gpio_o(gpio),
      .converting_o(conv)
   );

   // Released serial line falls to its pull-down level
   assign sdo_line = oe_n ? 1'b0 : dout;

   // Host model defaults match DIV and RWAIT above
   asct_host_model host (
      .clk_i(sys_clk),
      .dout_i(sdo_line),
      .cs_n_o(cs_n),
      .sclk_o(sclk),
      .din_o(din),
      .start_o(start),
      .reset_n_o(rst_n)
   );

   // Data ready falls and shortest high pulse, sampled away from the launching edge
   always @(negedge sys_clk) begin
      done_q <= done_n;
      if (done_q === 1'b1 && done_n === 1'b0) begin
         falls++;
         if (hi_len < hi_min) hi_min = hi_len;
      end
      hi_len = (done_n === 1'b1) ? hi_len + 1 : 0;
   end

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Bounded wait for a level on data ready
   task automatic wait_lvl(input logic v, output int n);
      n = 0;
      while (done_n !== v && n < 600) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 600) begin
         bad_count++;
         $display("Error at %0t: data ready wait got %h expected %h", $time, done_n, v);
      end
   endtask

   // One register write frame, output checked after the last fall
   task automatic wr_gpio(input logic [3:0] v);
      host.frame_begin();
      host.xfer(asct_pkg::CMD_REGISTER_WRITE_COMMAND, r1);
      host.xfer({4'hA, v}, r1);
      host.wait_n(2);
      `CHK(gpio, v);
      host.frame_end();
   endtask

   task automatic t_gpio();
      `CHK({gpio, done_n, dout, oe_n, conv}, 8'h0E);
      host.frame_begin();
      `CHK(oe_n, 1'b0);
      host.frame_end();
      `CHK(oe_n, 1'b1);
      wr_gpio(4'h5);
      wr_gpio(4'hA);
      $display("test gpio finished");
   endtask

   // Stray half byte must be dropped after the byte timeout
   task automatic t_timeout();
      host.frame_begin();
      for (int i = 0; i < 4; i++) host.xbit(1'b1, r1[0]);
      host.wait_n(160);
      host.xfer(asct_pkg::CMD_REGISTER_WRITE_COMMAND, r1);
      host.xfer(8'h03, r1);
      host.wait_n(2);
      `CHK(gpio, 4'h3);
      host.frame_end();
      $display("test timeout finished");
   endtask

   task automatic t_resets();
      host.pin_reset(2);
      `CHK(gpio, 4'h3);
      host.pin_reset(6);
      `CHK({gpio, done_n}, 5'h01);
      wr_gpio(4'h6);
      host.frame_begin();
      host.xfer(asct_pkg::CMD_RESET, r1);
      host.frame_end();
      `CHK(gpio, 4'h0);
      host.wait_n((RWAIT + 4) * DIV);
      wr_gpio(4'h9);
      $display("test resets finished");
   endtask

   // Single conversion; data ready must rise soon after start
   task automatic conv_once(input logic [15:0] v);
      result = v;
      host.set_start(1'b1);
      `CHK(done_n, 1'b1);
      `CHK(conv, 1'b1);
      host.set_start(1'b0);
      wait_lvl(1'b0, k);
      `CHK(k + 16 >= 24 * DIV, 1'b1);
      `CHK(conv, 1'b0);
   endtask

   task automatic read_out(input logic [15:0] v, input logic rdcmd);
      host.wait_n(4 * DIV + 2);
      host.frame_begin();
      if (!rdcmd) `CHK(dout, 1'b0);
      if (rdcmd) host.xfer(asct_pkg::CMD_RDATA, r1);
      host.xfer(8'h00, r1);
      `CHK(done_n, 1'b1);
      host.xfer(8'h00, r2);
      `CHK({r1, r2}, v);
      host.frame_end();
   endtask

   // Continuous mode stop request early or late before the next end
   task automatic stop_case(input int delay, input int exp);
      cont = 1'b1;
      host.set_start(1'b1);
      wait_lvl(1'b0, k);
      host.wait_n(delay);
      host.set_start(1'b0);
      falls = 0;
      host.wait_n(400);
      `CHK(falls, exp);
      `CHK(conv, 1'b0);
      cont = 1'b0;
      $display("test stop after %0d cycles finished", delay);
   endtask

   // Start and stop by command; a late stop lets one more conversion run
   task automatic t_cmds();
      cont = 1'b1;
      host.frame_begin();
      host.xfer(asct_pkg::CMD_START, r1);
      host.frame_end();
      `CHK(conv, 1'b1);
      wait_lvl(1'b0, k);
      host.wait_n(20);
      host.frame_begin();
      host.xfer(asct_pkg::CMD_STOP, r1);
      host.frame_end();
      falls = 0;
      host.wait_n(400);
      `CHK(falls, 2);
      `CHK(conv, 1'b0);
      cont = 1'b0;
      $display("test commands finished");
   endtask

   // Main sequence
   initial begin
      repeat (5) @(negedge sys_clk);
      nrst = 1'b1;
      host.wait_n(4);
      t_gpio();
      t_timeout();
      t_resets();
      conv_once(16'hA5C3);
      conv_once(16'h3C5A);
      read_out(16'h3C5A, 1'b0);
      read_out(16'h3C5A, 1'b1);
      $display("test conversion readout finished");
      stop_case(0, 1);
      stop_case(80, 2);
      t_cmds();
      `CHK(hi_min >= 24 * DIV, 1'b1);
      test_done();
   end

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      $display("Error at %0t: timeout got %h expected %h", $time, 1'b1, 1'b0);
      test_done();
   end
endmodule // asct_ctrl_top_tb_top

// ==== asct_host_model.sv ====
`timescale 1ns/10ps
module asct_host_model #(
   parameter int DIV = 2,
   parameter int RST_WAIT = 8
) (
   input wire logic clk_i,
   input wire logic dout_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic din_o,
   output logic start_o,
   output logic reset_n_o
);
   // Idle pins: deselected, clock low, reset released
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      din_o = 1'b0;
      start_o = 1'b0;
      reset_n_o = 1'b1;
   end

   // Every pin change lands just after a falling system clock edge
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // Chip select stays low for the whole frame
   task automatic frame_begin();
      cs_n_o = 1'b0;
      wait_n(4);
   endtask

   // Data line left toggled so a stale bit is never seen as valid
   task automatic frame_end();
      cs_n_o = 1'b1;
      din_o = ~din_o;
      wait_n(8);
   endtask

   // One bit: data set with the rise, held across the fall
   task automatic xbit(input logic b, output logic r);
      din_o = b;
      sclk_o = 1'b1;
      wait_n(4);
      r = dout_i;
      sclk_o = 1'b0;
      wait_n(4);
   endtask

   // Whole byte MSB first; the next byte may follow with no gap
   task automatic xfer(input logic [7:0] b, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         xbit(b[i], r[i]);
      end
   endtask

   // Start pin phase, never shorter than four converter clocks
   task automatic set_start(input logic v);
      start_o = v;
      wait_n(4 * DIV);
   endtask

   // Reset pin pulse followed by the recovery wait before any clock
   task automatic pin_reset(input int ticks);
      reset_n_o = 1'b0;
      wait_n(ticks * DIV);
      reset_n_o = 1'b1;
      wait_n((RST_WAIT + 4) * DIV);
   endtask
endmodule // asct_host_model

// ==== asct_pin_if.sv ====
`timescale 1ns/10ps
interface asct_pin_if;
   logic cs_n;
   logic din;
   logic rst_n;
   logic sclk_rise;
   logic sclk_fall;
   logic start_rise;
   logic start_fall;

   modport smp (output cs_n, output din, output rst_n, output sclk_rise, output sclk_fall,
                output start_rise, output start_fall);
   modport core (input cs_n, input din, input rst_n, input sclk_rise, input sclk_fall,
                 input start_rise, input start_fall);
endinterface

// ==== asct_pin_sync.sv ====
`timescale 1ns/10ps
module asct_pin_sync (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic din_i,
   input wire logic start_i,
   input wire logic reset_n_i,
   asct_pin_if.smp pin
);
   // Pin order in each vector: cs_n, sclk, din, start, reset_n
   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] s3;
   } asct_sync_t;

   localparam logic [4:0] PIN_RST = 5'h11;

   asct_sync_t st_r;
   asct_sync_t st_nxt;

   // Two flops per pin, third stage only for edge finding
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = {cs_n_i, sclk_i, din_i, start_i, reset_n_i};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= '{s1: PIN_RST, s2: PIN_RST, s3: PIN_RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Levels and edges seen by the core
   assign pin.cs_n = st_r.s2[4];
   assign pin.din = st_r.s2[2];
   assign pin.rst_n = st_r.s2[0];
   assign pin.sclk_rise = st_r.s2[3] && !st_r.s3[3];
   assign pin.sclk_fall = !st_r.s2[3] && st_r.s3[3];
   assign pin.start_rise = st_r.s2[1] && !st_r.s3[1];
   assign pin.start_fall = !st_r.s2[1] && st_r.s3[1];
endmodule // asct_pin_sync

// ==== asct_pkg.sv ====
package asct_pkg;

   // Clock rates and converter clock divider
   localparam int SYS_CLK_HZ = 40_000_000;
   localparam int CONV_CLK_HZ = 4_000_000;
   localparam int CLK_DIV = SYS_CLK_HZ / CONV_CLK_HZ;

   // Timing limits counted in converter clock periods
   localparam int RST_LOW_TCLK = 4;
   localparam int RST_WAIT_TCLK = 4096;
   localparam int START_HIGH_TCLK = 4;
   localparam int START_LOW_TCLK = 4;
   localparam int STOP_SETUP_TCLK = 32;
   localparam int DIRECT_HOLD_TCLK = 28;
   localparam int DIRECT_DELAY_TCLK = 4;
   localparam int DONE_RISE_TCLK = 2;
   localparam int DONE_HIGH_TCLK = 24;
   localparam int BYTE_TIMEOUT_TCLK = 32768;
   localparam int CONV_TCLK = 512;

   // Widths
   localparam int DATA_W = 16;
   localparam int GPIO_W = 4;

   // Command opcodes; reset, start and stop decoded on their upper seven bits, read and write on all eight
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_RESET = 8'h14;
   localparam logic [7:0] CMD_START = 8'h18;
   localparam logic [7:0] CMD_STOP = 8'h1C;
   localparam logic [7:0] CMD_RDATA = 8'h24;
   localparam logic [7:0] CMD_REGISTER_WRITE_COMMAND = 8'h50;

   // Values after reset
   localparam logic [GPIO_W-1:0] GPIO_RST = 4'h0;

   typedef enum logic [1:0] {
      SP_CMD = 2'b01,
      SP_WDATA = 2'b10
   } asct_sp_t;

   typedef enum logic [1:0] {
      CV_IDLE = 2'b01,
      CV_RUN = 2'b10
   } asct_cv_t;

   typedef struct packed {
      logic [15:0] div;
      logic tick;
      logic [2:0] rlow;
      logic rst_hold;
      logic [15:0] recov;
      asct_sp_t sp;
      logic [2:0] bitcnt;
      logic [7:0] sr;
      logic [15:0] tmo;
      logic frame_first;
      logic out_active;
      logic [DATA_W-1:0] out_sr;
      asct_cv_t cv;
      logic [15:0] conv_cnt;
      logic stop_pend;
      logic stop_late;
      logic done_n;
      logic [4:0] hi_cnt;
      logic [GPIO_W-1:0] gpio;
      logic dout;
      logic oe_n;
      logic converting;
   } asct_state_t;

   localparam asct_state_t ST_RST = '{
      sp: SP_CMD,
      cv: CV_IDLE,
      gpio: GPIO_RST,
      done_n: 1'b1,
      dout: 1'b1,
      oe_n: 1'b1,
      default: '0
   };

endpackage
